// [mpg_safety_pkg.sv]
// Shared constants, types and helpers for the multi-pulse and safety block
`default_nettype none
package mpg_safety_pkg;
    // Channel structure
    localparam int NUM_CH           = 3;
    localparam int CNT_W            = 10;
    localparam int CUR_W            = 12;
    localparam int THR_W            = 8;
    localparam int PRESCALE_W       = 11;
    // Internal pulse-clock prescale from the system clock
    localparam int INT_PRESCALE     = 16;
    // Core clock and disable-pin response time
    localparam int CLK_PERIOD_NS    = 20;
    localparam int DIS_RESPONSE_NS  = 1000;
    localparam int DIS_RESPONSE_CYC = (DIS_RESPONSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      DIS_RESPONSE_NS / CLK_PERIOD_NS;
    // Divider register fields
    localparam int DIV_MPG_LSB      = 0;
    localparam int DIV_MPG_MSB      = 3;
    localparam int DIV_PWM_LSB      = 4;
    localparam int DIV_PWM_MSB      = 7;
    // Operating control A fields
    localparam int CTRLA_ALARM_LSB  = 0;
    localparam int CTRLA_ALARM_MSB  = 3;
    // Operating control B fields
    localparam int CTRLB_DIS_BYPASS = 0;
    localparam int CTRLB_SOFT_OFF   = 1;
    localparam int CTRLB_AUTO_OFF   = 3;
    // Alarm clear control field
    localparam int ALARM_CLR_BIT    = 0;
    // Reset values
    localparam logic [CNT_W-1:0]      COUNT_RST  = 10'h000;
    localparam logic [NUM_CH-1:0]     ALARM_RST  = 3'h0;
    localparam logic [PRESCALE_W-1:0] PRESC_RST  = 11'h000;
    localparam logic [3:0]            TICK16_RST = 4'h0;
    localparam logic [7:0]            WIDTH_RST  = 8'h00;

    typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} phase_t;
    typedef enum logic       {AL_QUIET, AL_PULSE}     alarm_state_t;

    // Divider select to prescale mask: 1,2,4,16,256,512,1024,2048
    function automatic logic [PRESCALE_W-1:0] divMask(input logic [3:0] sel);
        logic [PRESCALE_W-1:0] m;
        m = 11'h000;
        case (sel)
            4'h0:    m = 11'h000;
            4'h1:    m = 11'h001;
            4'h2:    m = 11'h003;
            4'h3:    m = 11'h00F;
            4'h4:    m = 11'h0FF;
            4'h5:    m = 11'h1FF;
            4'h6:    m = 11'h3FF;
            default: m = 11'h7FF;
        endcase
        return m;
    endfunction

    // Alarm pulse width code to cycles: 1 -> 1, 2 -> 2, 3 -> 4, ... capped at 128
    function automatic logic [7:0] pulseWidth(input logic [3:0] code);
        logic [7:0] w;
        w = 8'h01;
        if (code >= 4'h8) begin
            w = 8'h80;
        end else if (code != 4'h0) begin
            w = 8'(8'h01 << (code - 4'h1));
        end
        return w;
    endfunction
endpackage
`default_nettype wire

// [mpg_channel.sv]
// One multi-pulse channel: latches counts on strobe rise and alternates on and off
`default_nettype none
module mpg_channel
    import mpg_safety_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             pulseTick,
    input  wire logic             channel_on_strobe,
    input  wire logic [CNT_W-1:0] onCount,
    input  wire logic [CNT_W-1:0] offCount,
    output logic                  pulseOn
);
    logic             strobePrev_reg;
    logic [CNT_W-1:0] onLat_reg;
    logic [CNT_W-1:0] offLat_reg;
    logic [CNT_W-1:0] remain_reg;
    logic [CNT_W-1:0] remain_next;
    logic             mpgEn_reg;
    logic             pulseOn_next;
    phase_t           phase_reg;
    phase_t           phase_next;
    wire              strobeRise = channel_on_strobe & ~strobePrev_reg;
    wire              phaseEnd   = pulseTick & mpgEn_reg & (remain_reg == 10'h001);

    // Phase sequencing; strobe low always parks the channel
    always_comb begin
        phase_next  = phase_reg;
        remain_next = remain_reg;
        case (phase_reg)
            PH_IDLE: phase_next = PH_IDLE;
            PH_ON: begin
                if (phaseEnd) begin
                    phase_next  = PH_OFF;
                    remain_next = offLat_reg;
                end else if (pulseTick && mpgEn_reg) begin
                    remain_next = remain_reg - 10'h001;
                end
            end
            PH_OFF: begin
                if (phaseEnd) begin
                    phase_next  = PH_ON;
                    remain_next = onLat_reg;
                end else if (pulseTick && mpgEn_reg) begin
                    remain_next = remain_reg - 10'h001;
                end
            end
            default: phase_next = PH_IDLE;
        endcase
        if (strobeRise) begin
            phase_next  = PH_ON;
            remain_next = onCount;
        end else if (!channel_on_strobe) begin
            phase_next = PH_IDLE;
        end
    end

    // Zero count leaves the output plainly on for the strobe
    assign pulseOn_next = channel_on_strobe && (phase_next == PH_ON || phase_next == PH_OFF) &&
                          (!(strobeRise ? (onCount != 10'h000 && offCount != 10'h000)
                                        : mpgEn_reg) || phase_next == PH_ON);

    // Counts are sampled only at strobe rise, so mid-strobe writes wait
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strobePrev_reg <= 1'b0;
            onLat_reg      <= COUNT_RST;
            offLat_reg     <= COUNT_RST;
            mpgEn_reg      <= 1'b0;
        end else begin
            strobePrev_reg <= channel_on_strobe;
            if (strobeRise) begin
                onLat_reg  <= onCount;
                offLat_reg <= offCount;
                mpgEn_reg  <= (onCount != 10'h000) && (offCount != 10'h000);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_reg  <= PH_IDLE;
            remain_reg <= COUNT_RST;
            pulseOn    <= 1'b0;
        end else begin
            phase_reg  <= phase_next;
            remain_reg <= remain_next;
            pulseOn    <= pulseOn_next;
        end
    end

    chk_strobe_low_off : assert property (@(posedge core_clk) disable iff (!rst_n)
        !channel_on_strobe |=> !pulseOn)
        else $error("pulse output on while strobe low");
endmodule
`default_nettype wire

// [alarm_pin_ctrl.sv]
// Alarm pin driver: status level or one pulse per alarm change
`default_nettype none
module alarm_pin_ctrl
    import mpg_safety_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       alarmNow,
    input  wire logic [3:0] modeCode,
    output logic            alarmActive
);
    logic         alarmPrev_reg;
    logic [7:0]   width_reg;
    alarm_state_t state_reg;
    wire          statusMode  = (modeCode == 4'h0);
    wire          alarmChange = alarmNow ^ alarmPrev_reg;

    // A change arriving mid-pulse restarts the pulse rather than being dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarmPrev_reg <= 1'b0;
            width_reg     <= WIDTH_RST;
            state_reg     <= AL_QUIET;
            alarmActive   <= 1'b0;
        end else begin
            alarmPrev_reg <= alarmNow;
            if (statusMode) begin
                state_reg   <= AL_QUIET;
                alarmActive <= alarmNow;
            end else if (alarmChange) begin
                state_reg   <= AL_PULSE;
                width_reg   <= pulseWidth(modeCode) - 8'h01;
                alarmActive <= 1'b1;
            end else begin
                case (state_reg)
                    AL_PULSE: begin
                        if (width_reg == 8'h00) begin
                            state_reg   <= AL_QUIET;
                            alarmActive <= 1'b0;
                        end else begin
                            width_reg <= width_reg - 8'h01;
                        end
                    end
                    default: begin
                        state_reg   <= AL_QUIET;
                        alarmActive <= 1'b0;
                    end
                endcase
            end
        end
    end

    chk_status_follows : assert property (@(posedge core_clk) disable iff (!rst_n)
        (modeCode == 4'h0) && $stable(modeCode) |-> alarmActive == $past(alarmNow))
        else $error("status mode pin does not follow alarm");
    chk_one_cycle_pulse : assert property (@(posedge core_clk) disable iff (!rst_n)
        (modeCode == 4'h1) ##0 $stable(modeCode) ##0 (alarmNow != $past(alarmNow))
        ##1 (modeCode == 4'h1) |-> alarmActive ##1 (!alarmActive || $past(alarmChange)))
        else $error("interrupt pulse of width one is wrong");
endmodule
`default_nettype wire

// [multi_pulse_and_overcurrent_safety.sv]
// Top of the multi-pulse generator with overcurrent and disable safety logic
`default_nettype none
// What this block does
// - Two 10-bit counts per channel: on, off
// - On phase drives gain plus offset, off zero
// - Counts to 1023; period is on plus off
// - Pulse clock may come from external clock
// - Divider select gives 1 to 2048
// - Pulse divider independent of PWM divider bits
// - On counts map to channels in reverse
// - Counts latched at strobe rising edge only
// - Zero on or off count disables pulsing
// - PWM delay and pulse timing independently clocked
// - Disable pin cuts current within one microsecond
// - Per-channel threshold compare on current MSB byte
// - Sticky alarm, cleared by writing clear bit
// - External clock pin may become alarm output
// - Auto shutoff zeroes over-threshold channel current
// - Status mode pin follows alarm, even briefly
// - Interrupt mode pulses per alarm change
// - Software can disable output stage
// - Internal pulse clock is system clock over 16
module multi_pulse_and_overcurrent_safety
    import mpg_safety_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter int COUNT_W  = CNT_W
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic [2:0]                   channel_on_strobe,
    input  wire logic [2:0][CNT_W-1:0]        pulseOnCount,
    input  wire logic [2:0][CNT_W-1:0]        pulseOffCount,
    input  wire logic [7:0]                   clockDivider,
    input  wire logic                         multiPulseExtClk,
    input  wire logic                         pwmExtClk,
    input  wire logic                         extClkIn,
    input  wire logic                         alarmOnClkPin,
    input  wire logic [2:0][CUR_W-1:0]        gainOffsetLevel,
    input  wire logic [2:0][CUR_W-1:0]        measuredCurrent,
    input  wire logic [2:0][THR_W-1:0]        alarmThreshold,
    input  wire logic [7:0]                   operating_control_a,
    input  wire logic [7:0]                   operating_control_b,
    input  wire logic                         alarmClearWrite,
    input  wire logic [7:0]                   alarmClearData,
    input  wire logic                         disablePin,
    output logic [2:0][CUR_W-1:0]             channel_current_output,
    output logic                              groundPathEn,
    output logic [NUM_CH-1:0]                 alarmStatus,
    output logic                              alarmPinOut,
    output logic                              alarmPinOe,
    output logic                              pulseTickOut
);
    // Elaboration-time guard: the logic is built for three 10-bit channels
    if (CHANNELS != NUM_CH || COUNT_W != CNT_W) begin : g_bad_params
        $error("channel count and count width must match the package");
    end

    // ------------------------------------------------------------------
    // Pulse clock source: internal divide by 16 or external clock edges
    // ------------------------------------------------------------------
    logic [3:0]            int16_reg;
    logic                  extPrev_reg;
    logic [PRESCALE_W-1:0] presc_reg;
    logic [PRESCALE_W-1:0] presc_next;
    logic                  pulseTick_reg;
    logic                  pulseTick_next;

    wire       intTick    = (int16_reg == 4'(INT_PRESCALE - 1));
    wire       extTick    = extClkIn & ~extPrev_reg;
    wire       srcTick    = multiPulseExtClk ? extTick : intTick;
    // Only the low nibble steers the pulse clock; the PWM nibble is left alone
    wire [3:0] mpgDivSel  = clockDivider[DIV_MPG_MSB:DIV_MPG_LSB];
    wire [PRESCALE_W-1:0] divLimit = divMask(mpgDivSel);
    wire       prescWrap  = srcTick && (presc_reg >= divLimit);

    // Prescaler; a divider change mid-count takes effect at once via >=
    always_comb begin
        presc_next     = presc_reg;
        pulseTick_next = 1'b0;
        if (srcTick) begin
            if (prescWrap) begin
                presc_next     = PRESC_RST;
                pulseTick_next = 1'b1;
            end else begin
                presc_next = presc_reg + 11'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int16_reg     <= TICK16_RST;
            extPrev_reg   <= 1'b0;
            presc_reg     <= PRESC_RST;
            pulseTick_reg <= 1'b0;
        end else begin
            int16_reg     <= int16_reg + 4'h1;
            extPrev_reg   <= extClkIn;
            presc_reg     <= presc_next;
            pulseTick_reg <= pulseTick_next;
        end
    end

    assign pulseTickOut = pulseTick_reg;

    // ------------------------------------------------------------------
    // Pulse channels; the on-count bank is wired in reverse order
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] pulseOn;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        mpg_channel u_chan (
            .core_clk          (core_clk),
            .rst_n             (rst_n),
            .pulseTick         (pulseTick_reg),
            .channel_on_strobe (channel_on_strobe[ch]),
            .onCount           (pulseOnCount[NUM_CH-1-ch]),
            .offCount          (pulseOffCount[ch]),
            .pulseOn           (pulseOn[ch])
        );
    end

    // ------------------------------------------------------------------
    // Overcurrent compare and sticky alarm status
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] overCurrent;
    logic [NUM_CH-1:0] alarm_next;

    // Only the current MSB byte is compared, so trips have 16-code granularity
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cmp
        assign overCurrent[ch] = measuredCurrent[ch][CUR_W-1 -: THR_W] >
                                 alarmThreshold[ch];
    end

    wire alarmClear = alarmClearWrite & alarmClearData[ALARM_CLR_BIT];
    // A trip in the clearing cycle survives the clear
    assign alarm_next = (alarmClear ? ALARM_RST : alarmStatus) | overCurrent;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarmStatus <= ALARM_RST;
        end else begin
            alarmStatus <= alarm_next;
        end
    end

    // ------------------------------------------------------------------
    // Current output gating: pulse phase, soft disable, disable pin, auto off
    // ------------------------------------------------------------------
    wire disBypass  = operating_control_b[CTRLB_DIS_BYPASS];
    wire softOff    = operating_control_b[CTRLB_SOFT_OFF];
    wire autoOff    = operating_control_b[CTRLB_AUTO_OFF];
    wire pinKill    = disablePin & ~disBypass;
    logic [2:0][CUR_W-1:0] current_next;
    logic [NUM_CH-1:0]     chanKill;

    // Level cut happens the cycle after the pin rises, far inside the limit
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_out
        assign chanKill[ch]     = softOff | pinKill | (autoOff & overCurrent[ch]);
        assign current_next[ch] = (pulseOn[ch] && !chanKill[ch]) ?
                                  gainOffsetLevel[ch] : 12'h000;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            channel_current_output <= '0;
            groundPathEn           <= 1'b0;
        end else begin
            channel_current_output <= current_next;
            groundPathEn           <= ~pinKill;
        end
    end

    // ------------------------------------------------------------------
    // Alarm pin: shares the external clock pin when nothing clocks from it
    // ------------------------------------------------------------------
    logic alarmActive;
    wire  pinFree  = ~multiPulseExtClk & ~pwmExtClk;
    wire  pinAlarm = alarmOnClkPin & pinFree;

    alarm_pin_ctrl u_alarm (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .alarmNow    (|overCurrent),
        .modeCode    (operating_control_a[CTRLA_ALARM_MSB:CTRLA_ALARM_LSB]),
        .alarmActive (alarmActive)
    );

    // Open collector: pin only ever pulled low, never driven high
    assign alarmPinOut = 1'b0;
    assign alarmPinOe  = pinAlarm & alarmActive;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_strobe_rise(int c);
        !channel_on_strobe[c] ##1 channel_on_strobe[c];
    endsequence

    chk_disable_cuts : assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(disablePin) && !disBypass |-> ##[1:50] (!groundPathEn &&
        channel_current_output == '0))
        else $error("disable pin did not cut current in time");

    chk_alarm_sticky : assert property (@(posedge core_clk) disable iff (!rst_n)
        alarmStatus[1] && !alarmClear |=> alarmStatus[1])
        else $error("alarm status dropped without clear");

    chk_alarm_set : assert property (@(posedge core_clk) disable iff (!rst_n)
        overCurrent[1] |=> alarmStatus[1])
        else $error("over threshold current did not set alarm");

    chk_clear_works : assert property (@(posedge core_clk) disable iff (!rst_n)
        alarmClear && overCurrent == '0 |=> alarmStatus == '0)
        else $error("alarm clear did not clear status");

    chk_auto_off : assert property (@(posedge core_clk) disable iff (!rst_n)
        autoOff && overCurrent[1] |=> channel_current_output[1] == '0)
        else $error("auto shutoff left current on");

    chk_soft_off : assert property (@(posedge core_clk) disable iff (!rst_n)
        softOff |=> channel_current_output == '0)
        else $error("soft disable left current on");

    chk_on_level : assert property (@(posedge core_clk) disable iff (!rst_n)
        pulseOn[0] && !chanKill[0] |=> channel_current_output[0] ==
        $past(gainOffsetLevel[0]))
        else $error("on phase level is not gain plus offset");

    chk_start_on : assert property (@(posedge core_clk) disable iff (!rst_n)
        s_strobe_rise(1) |=> pulseOn[1])
        else $error("channel did not start in on phase");

    chk_pin_busy : assert property (@(posedge core_clk) disable iff (!rst_n)
        (multiPulseExtClk || pwmExtClk) |-> !alarmPinOe)
        else $error("alarm drove a pin used as clock");

    chk_tick_rate : assert property (@(posedge core_clk) disable iff (!rst_n)
        !multiPulseExtClk && mpgDivSel == 4'h0 && $stable(mpgDivSel) && pulseTick_reg
        ##1 !multiPulseExtClk [*8] |-> !pulseTick_reg)
        else $error("pulse tick faster than divider allows");
endmodule
`default_nettype wire

// [mpg_host_model.sv]
// Host model: count registers loaded through byte-wide writes
`default_nettype none
module mpg_host_model
    import mpg_safety_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  byteWr,
    input  wire logic [3:0]            byteAddr,
    input  wire logic [7:0]            byteData,
    output logic      [2:0][CNT_W-1:0] onCnt,
    output logic      [2:0][CNT_W-1:0] offCnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CNT_W-1:0] cntReg [8];
    // Even address low byte, odd the top bits; a full frame update takes twelve writes
    always @(posedge core_clk) begin
        if (byteWr) begin
            if (byteAddr[0]) begin
                cntReg[byteAddr[3:1]][9:8] <= byteData[1:0];
            end else begin
                cntReg[byteAddr[3:1]][7:0] <= byteData;
            end
        end
    end
    // Entries 0 to 2 are on counts, 3 to 5 off counts
    assign onCnt  = {cntReg[2], cntReg[1], cntReg[0]};
    assign offCnt = {cntReg[5], cntReg[4], cntReg[3]};
endmodule
`default_nettype wire

// [tb_top.sv]
// Bench for the multi-pulse generator and safety logic
`default_nettype none
module tb_top
    import mpg_safety_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  core_clk, rst_n, mpgExt, pwmExt, extClk, extRun, clrWr, disPin, wr;
    logic                  gnd, pinOut, pinOe, tick, sampleNow;
    logic [2:0]            strobe, st, z;
    logic [3:0]            addr;
    logic [7:0]            div, ctlA, ctlB, clrData, data;
    logic [2:0][CUR_W-1:0] lvl, meas, cur;
    logic [2:0][THR_W-1:0] thr;
    logic [2:0][CNT_W-1:0] onCnt, offCnt;
    logic [40:0]           expQ[$];
    int                    seed, miscompares, nCompared, cycles, n;
    int                    divTab[8] = '{1, 2, 4, 16, 256, 512, 1024, 2048};
    wire  [40:0]           obs = {pinOe, st, gnd, cur};

    multi_pulse_and_overcurrent_safety i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .channel_on_strobe(strobe), .pulseOnCount(onCnt), .pulseOffCount(offCnt),
        .clockDivider(div), .multiPulseExtClk(mpgExt), .pwmExtClk(pwmExt), .extClkIn(extClk),
        .alarmOnClkPin(1'h1), .gainOffsetLevel(lvl), .measuredCurrent(meas),
        .alarmThreshold(thr), .operating_control_a(ctlA), .operating_control_b(ctlB),
        .alarmClearWrite(clrWr), .alarmClearData(clrData), .disablePin(disPin),
        .channel_current_output(cur), .groundPathEn(gnd), .alarmStatus(st),
        .alarmPinOut(pinOut), .alarmPinOe(pinOe), .pulseTickOut(tick));
    mpg_host_model i_host (.core_clk(core_clk), .byteWr(wr), .byteAddr(addr),
        .byteData(data), .onCnt(onCnt), .offCnt(offCnt));

    // Free-running clock; the external clock toggles on edges so it is phase-locked here
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (extRun) extClk <= ~extClk;

    task automatic check(input logic [40:0] seen, input logic [40:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (miscompares == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // Note an expectation; the monitor samples one edge later
    task automatic noteExp(input logic [40:0] e);
        expQ.push_back(e);
        sampleNow <= 1'h1;
        @(posedge core_clk);
        sampleNow <= 1'h0;
    endtask
    always @(posedge core_clk) if (sampleNow) check(obs, expQ.pop_front());
    // Caller drops the write strobe after the last count, so it never toggles twice
    task automatic setCnt(input int i, input logic [9:0] v);
        wr <= 1'h1;
        addr <= 4'(2 * i);
        data <= v[7:0];
        tk(1);
        addr <= 4'(2 * i + 1);
        data <= {6'h00, v[9:8]};
        tk(1);
    endtask
    // Records which channels ever showed zero current over a stretch of cycles
    task automatic track;
        z = 3'h0;
        repeat (150) begin
            @(negedge core_clk);
            for (int i = 0; i < 3; i++) z[i] = z[i] | (cur[i] === 12'h000);
        end
        tk(1);
    endtask
    // Measures cycles between pulse ticks, sampled on the falling edge
    task automatic gap(output int k);
        do @(negedge core_clk); while (tick !== 1'h1);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (tick !== 1'h1 && k < 9000);
        // Return on a rising edge so the caller's next drive lands there
        @(posedge core_clk);
    endtask
    // Hang guard counted as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        seed = 66;
        {core_clk, rst_n, mpgExt, pwmExt, extClk, extRun, clrWr, disPin, wr, sampleNow} = '0;
        {strobe, addr, div, ctlA, ctlB, clrData, data, meas} = '0;
        for (int i = 0; i < 3; i++) begin
            lvl[i] = 12'h800 | 12'($random(seed));
            thr[i] = 8'h40 | 8'($random(seed) & 8'h3F);
        end
        tk(5);
        rst_n <= 1'h1;
        tk(1);
        noteExp({5'h01, 36'h0});
        setCnt(2, 10'h000);
        setCnt(1, 10'h002);
        setCnt(0, 10'h003);
        setCnt(3, 10'h005);
        setCnt(4, 10'h001);
        setCnt(5, 10'h000);
        wr <= 1'h0;
        strobe <= 3'h7;
        tk(3);
        noteExp({5'h01, lvl});
        setCnt(1, 10'h000);
        wr <= 1'h0;
        track();
        check(41'(z), 41'(3'h2));
        strobe <= 3'h0;
        tk(3);
        noteExp({5'h01, 36'h0});
        strobe <= 3'h7;
        // Current follows the strobe two edges later; start watching after that
        tk(2);
        track();
        check(41'(z), 41'(3'h0));
        meas[1] <= {thr[1] + 8'h01, 4'hF};
        tk(4);
        noteExp({5'h15, lvl});
        ctlB <= 8'h08;
        tk(3);
        noteExp({5'h15, lvl[2], 12'h000, lvl[0]});
        meas[1] <= {thr[1], 4'hF};
        tk(4);
        noteExp({5'h05, lvl});
        clrWr <= 1'h1;
        clrData <= 8'hFE;
        tk(1);
        clrWr <= 1'h0;
        tk(2);
        noteExp({5'h05, lvl});
        clrWr <= 1'h1;
        clrData <= 8'h01;
        tk(1);
        clrWr <= 1'h0;
        tk(2);
        noteExp({5'h01, lvl});
        pwmExt <= 1'h1;
        meas[1] <= {thr[1] + 8'h01, 4'h0};
        tk(4);
        noteExp({5'h05, lvl[2], 12'h000, lvl[0]});
        pwmExt <= 1'h0;
        ctlA <= 8'h03;
        tk(30);
        meas[1] <= 12'h000;
        n = 0;
        repeat (30) begin
            @(negedge core_clk);
            n += int'(pinOe === 1'h1);
        end
        check(41'(n), 41'(4));
        tk(1);
        // One-cycle interrupt pulses: trip and release with the mode already settled
        ctlA <= 8'h01;
        tk(1);
        meas[1] <= {thr[1] + 8'h01, 4'h0};
        tk(2);
        meas[1] <= 12'h000;
        tk(4);
        disPin <= 1'h1;
        tk(2);
        noteExp({5'h04, 36'h0});
        ctlB <= 8'h09;
        tk(3);
        noteExp({5'h05, lvl});
        ctlB <= 8'h0B;
        tk(3);
        noteExp({5'h05, 36'h0});
        {disPin, ctlB, strobe} <= '0;
        mpgExt <= 1'h1;
        extRun <= 1'h1;
        for (int c = 0; c < 8; c++) begin
            div <= {4'($random(seed)), 4'(c)};
            gap(n);
            gap(n);
            check(41'(n), 41'(2 * divTab[c]));
        end
        mpgExt <= 1'h0;
        div <= 8'h00;
        gap(n);
        gap(n);
        check(41'(n), 41'(INT_PRESCALE));
        tk(3);
        end_sim();
    end
endmodule
`default_nettype wire
